// ---- hw/qdc_counter.sv ----
// qdc_counter: two-phase up/down counter channel with ahb-lite register access.
// assumes power mode comes from the clock generator and is synchronous to clock;
// warm-up after stop is complete once powerMode leaves PM_STOP.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module qdc_counter
    import qdc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // ahb-lite slave
    input wire qdc_ahb_req_t busReq,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // encoder inputs and sampling ticks
    input wire logic phaseA,
    input wire logic phaseB,
    input wire logic lowSpeedTick,
    input wire logic prescaleBaseTick,
    // system power state
    input wire qdc_power_t powerMode,
    // events and counter value
    output logic countIrq,
    output logic wakeReq,
    output logic [15:0] countValue
);

    // registers
    qdc_ctrl_t ctrl_r;
    qdc_status_t status_r;
    logic runRun_r;
    logic runUdce_r;
    logic runCk_r;
    logic [1:0] modeClk_r;
    logic [15:0] cnt_r;
    logic [31:0] hrdata_r;
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] div_r;
    logic [1:0] pinState_r;
    logic prevA_r;
    qdc_prog_t prog_r;
    qdc_prog_t prog_nxt;
    logic countIrq_r;
    logic wakeReq_r;

    // combinational terms
    logic addrPhase;
    logic statusRead;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic wrCtrl;
    logic wrRun;
    logic wrMode;
    logic udceSet;
    logic frozen;
    logic active;
    logic sampleTick;
    logic [1:0] filt;
    logic changed;
    logic stepUp;
    logic stepDn;
    logic irregular;
    logic countUp;
    logic countDn;
    logic timerTick;
    qdc_status_t newEvents;

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign countIrq = countIrq_r;
    assign wakeReq = wakeReq_r;
    assign countValue = cnt_r;

    // address phase decode; upper address bits belong to the system decoder
    assign addrPhase = busReq.hsel && busReq.htrans[1] && hready;
    assign rdAddr = busReq.haddr[7:0];
    assign statusRead = addrPhase && !busReq.hwrite && (rdAddr == OFF_STATUS);
    assign wrCtrl = wrPend_r && (wrAddr_r == OFF_CTRL);
    assign wrRun = wrPend_r && (wrAddr_r == OFF_RUN);
    assign wrMode = wrPend_r && (wrAddr_r == OFF_MODE);
    assign udceSet = wrRun && hwdata[RUN_UDCE_BIT] && !runUdce_r;

    // read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rdData = 32'h0;
        case (rdAddr)
            OFF_CTRL: begin
                rdData[CTRL_EN_BIT] = ctrl_r.enable;
                rdData[CTRL_SYNC_BIT] = ctrl_r.syncMode;
                rdData[CTRL_NF_BIT] = ctrl_r.noiseFilter;
                rdData[CTRL_QUAD_BIT] = ctrl_r.quadMode;
            end
            OFF_STATUS: begin
                rdData[ST_OVF_BIT] = status_r.overflow;
                rdData[ST_UDF_BIT] = status_r.underflow;
                rdData[ST_CNT_BIT] = status_r.countEvent;
            end
            OFF_RUN: begin
                rdData[RUN_RUN_BIT] = runRun_r;
                rdData[RUN_UDCE_BIT] = runUdce_r;
                rdData[RUN_CK_BIT] = runCk_r;
            end
            OFF_MODE: rdData[MODE_CLK_LSB +: 2] = modeClk_r;
            OFF_COUNT: rdData[15:0] = cnt_r;
            default: rdData = 32'h0;
        endcase
    end

    // bus pipeline: read data captured at the address phase, write done in the data phase
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h0;
        end else begin
            wrPend_r <= addrPhase && busReq.hwrite;
            if (addrPhase) begin
                wrAddr_r <= rdAddr;
            end
            if (addrPhase && !busReq.hwrite) begin
                hrdata_r <= rdData;
            end
        end
    end

    // control register; the write-zero bit and read-only bits are simply not stored
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= '0;
        end else if (wrCtrl) begin
            ctrl_r.enable <= hwdata[CTRL_EN_BIT];
            ctrl_r.syncMode <= hwdata[CTRL_SYNC_BIT];
            ctrl_r.noiseFilter <= hwdata[CTRL_NF_BIT];
            ctrl_r.quadMode <= hwdata[CTRL_QUAD_BIT];
        end
    end

    // run and mode registers; clock select is stored only, the prescaler lives elsewhere
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            runRun_r <= CTRL_RESET[0];
            runUdce_r <= CTRL_RESET[0];
            runCk_r <= CTRL_RESET[0];
            modeClk_r <= CLK_PRESCALER_OFF;
        end else begin
            if (wrRun) begin
                runRun_r <= hwdata[RUN_RUN_BIT];
                runUdce_r <= hwdata[RUN_UDCE_BIT];
                runCk_r <= hwdata[RUN_CK_BIT];
            end
            if (wrMode) begin
                modeClk_r <= hwdata[MODE_CLK_LSB +: 2];
            end
        end
    end

    // two-flop synchroniser; costs up to one clock of phase uncertainty
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end else begin
            sync1_r <= {phaseA, phaseB};
            sync2_r <= sync1_r;
        end
    end

    qdc_glitch_filter u_filter (
        .clock(clock),
        .arst_n(arst_n),
        .enable(ctrl_r.noiseFilter),
        .rawIn(sync2_r),
        .cleanOut(filt)
    );

    // stop freezes the counter, held pin state and sample divider (synchroniser and filter keep running); sleep keeps the channel alive
    assign frozen = (powerMode == PM_STOP);
    assign active = ctrl_r.enable && runRun_r && !frozen;

    // divide the prescaler base tick by four for high-speed sampling
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 2'h0;
        end else if (!frozen && prescaleBaseTick) begin
            div_r <= div_r + 2'h1;
        end
    end
    assign sampleTick = runCk_r ? (prescaleBaseTick && div_r == SAMPLE_DIV_LAST) : lowSpeedTick;

    // transition classification of the pin state {phaseA, phaseB}
    assign changed = active && runUdce_r && sampleTick && (filt != pinState_r);
    always_comb begin
        stepUp = 1'b0;
        stepDn = 1'b0;
        unique case (pinState_r)
            2'h0: begin
                stepUp = (filt == 2'h2);
                stepDn = (filt == 2'h1);
            end
            2'h2: begin
                stepUp = (filt == 2'h3);
                stepDn = (filt == 2'h0);
            end
            2'h3: begin
                stepUp = (filt == 2'h1);
                stepDn = (filt == 2'h2);
            end
            2'h1: begin
                stepUp = (filt == 2'h0);
                stepDn = (filt == 2'h3);
            end
        endcase
    end
    // diagonal jumps (0<->3, 1<->2) are not a valid quadrature step
    assign irregular = changed && !stepUp && !stepDn;

    // normal decoding: one count per full four-step cycle in one direction
    always_comb begin
        prog_nxt = prog_r;
        if (changed) begin
            unique case (1'b1)
                irregular: prog_nxt = PR_IDLE;
                stepUp: begin
                    unique case (prog_r)
                        PR_UP1: prog_nxt = PR_UP2;
                        PR_UP2: prog_nxt = PR_UP3;
                        PR_UP3: prog_nxt = PR_IDLE;
                        default: prog_nxt = (pinState_r == 2'h0) ? PR_UP1 : PR_IDLE;
                    endcase
                end
                stepDn: begin
                    unique case (prog_r)
                        PR_DN1: prog_nxt = PR_DN2;
                        PR_DN2: prog_nxt = PR_DN3;
                        PR_DN3: prog_nxt = PR_IDLE;
                        default: prog_nxt = (pinState_r == 2'h0) ? PR_DN1 : PR_IDLE;
                    endcase
                end
            endcase
        end
    end

    assign countUp = changed && stepUp && (ctrl_r.quadMode || prog_r == PR_UP3);
    assign countDn = changed && stepDn && (ctrl_r.quadMode || prog_r == PR_DN3);

    // held pin state; not updated in stop, so the first sample after stop counts the difference
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinState_r <= 2'h0;
            prog_r <= PR_IDLE;
            prevA_r <= 1'b0;
        end else if (udceSet) begin
            pinState_r <= filt;
            prog_r <= PR_IDLE;
            prevA_r <= filt[1];
        end else if (!frozen) begin
            prevA_r <= filt[1];
            if (changed) begin
                pinState_r <= filt;
                prog_r <= prog_nxt;
            end
        end
    end

    // plain timer mode counts rising edges of phase A as an external clock
    assign timerTick = active && !runUdce_r && filt[1] && !prevA_r;

    // the counter itself
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= COUNT_RESET;
        end else if (udceSet) begin
            cnt_r <= COUNT_INIT;
        end else if (countUp || timerTick) begin
            cnt_r <= cnt_r + 16'h1;
        end else if (countDn) begin
            cnt_r <= cnt_r - 16'h1;
        end
    end

    // events of this cycle
    always_comb begin
        newEvents.overflow = countUp && (cnt_r == COUNT_MAX);
        newEvents.underflow = countDn && (cnt_r == COUNT_MIN);
        newEvents.countEvent = countUp || countDn;
    end

    // read-clear status: an event in the clearing cycle survives
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= '0;
        end else if (statusRead) begin
            status_r <= newEvents;
        end else begin
            status_r <= status_r | newEvents;
        end
    end

    // interrupt pulse per up/down count (timer counts raise none); during sleep it also asks for wake-up
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            countIrq_r <= 1'b0;
            wakeReq_r <= 1'b0;
        end else begin
            countIrq_r <= countUp || countDn;
            wakeReq_r <= (countUp || countDn) && (powerMode == PM_SLEEP);
        end
    end

    // checks
    a_count_irq_pulse: assert property (@(posedge clock) disable iff (!arst_n)
        (countUp || countDn) |=> countIrq) else $error("count without interrupt pulse");
    a_status_read_clear: assert property (@(posedge clock) disable iff (!arst_n)
        statusRead && !countUp && !countDn |=> status_r == '0) else $error("status not cleared by read");
    a_status_bits_only: assert property (@(posedge clock) disable iff (!arst_n)
        statusRead |=> hrdata[31:5] == 27'h0 && hrdata[1:0] == 2'h0) else $error("reserved status bits set");
    a_overflow_wrap: assert property (@(posedge clock) disable iff (!arst_n)
        countUp && cnt_r == COUNT_MAX && !udceSet |=> cnt_r == COUNT_MIN && status_r.overflow)
        else $error("overflow did not wrap to zero");
    a_underflow_wrap: assert property (@(posedge clock) disable iff (!arst_n)
        countDn && cnt_r == COUNT_MIN && !udceSet |=> cnt_r == COUNT_MAX && status_r.underflow)
        else $error("underflow did not wrap to all ones");
    a_init_value: assert property (@(posedge clock) disable iff (!arst_n)
        udceSet |=> cnt_r == COUNT_INIT && runUdce_r) else $error("up/down entry did not load init value");
    a_sleep_wake: assert property (@(posedge clock) disable iff (!arst_n)
        (countUp || countDn) && powerMode == PM_SLEEP |=> wakeReq && countIrq) else $error("no wake from sleep");
    a_stop_hold: assert property (@(posedge clock) disable iff (!arst_n)
        frozen && !udceSet |=> cnt_r == $past(cnt_r) && pinState_r == $past(pinState_r))
        else $error("counter moved in stop");
    a_quad_step: assert property (@(posedge clock) disable iff (!arst_n)
        changed && stepUp && ctrl_r.quadMode && !udceSet |=> cnt_r == $past(cnt_r) + 16'h1)
        else $error("quadruple step not counted");
    a_normal_partial: assert property (@(posedge clock) disable iff (!arst_n)
        changed && !ctrl_r.quadMode && prog_r != PR_UP3 && prog_r != PR_DN3 && !udceSet
        |=> cnt_r == $past(cnt_r)) else $error("normal mode counted before full sequence");
    a_irregular_skip: assert property (@(posedge clock) disable iff (!arst_n)
        irregular && !udceSet |=> cnt_r == $past(cnt_r) && prog_r == PR_IDLE)
        else $error("irregular change counted or progress kept");
    a_ctrl_reserved: assert property (@(posedge clock) disable iff (!arst_n)
        addrPhase && !busReq.hwrite && rdAddr == OFF_CTRL |=> hrdata[6:4] == 3'h0 && hrdata[0] == 1'b0)
        else $error("reserved control bits not zero");

endmodule

// ---- hw/qdc_glitch_filter.sv ----
// qdc_glitch_filter: per-input digital noise filter for the two phase inputs.
// assumes inputs are already synchronised to clock.
`timescale 1ns/1ps
module qdc_glitch_filter
    import qdc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // control
    input wire logic enable,
    // data
    input wire logic [1:0] rawIn,
    output logic [1:0] cleanOut
);

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_bit
            logic [2:0] stable_r;
            // a level must persist for the whole window before it passes through
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    stable_r <= 3'h0;
                    cleanOut[i] <= 1'b0;
                end else if (!enable) begin
                    stable_r <= 3'h0;
                    cleanOut[i] <= rawIn[i];
                end else if (rawIn[i] == cleanOut[i]) begin
                    stable_r <= 3'h0;
                end else if (stable_r == FILTER_LAST) begin
                    stable_r <= 3'h0;
                    cleanOut[i] <= rawIn[i];
                end else begin
                    stable_r <= stable_r + 3'h1;
                end
            end
        end
    endgenerate

endmodule

// ---- hw/qdc_pkg.sv ----
// qdc_pkg: constants, register map and carrier types for the two-phase up/down counter channel.
// assumes a single 40 MHz system clock and an ahb-lite master issuing single whole-word transfers.
//
// Functional notes
// - mode enable 0 plain timer, 1 up/down
// - every up/down count raises the count interrupt
// - status bits 2,3,4: overflow, underflow, count
// - status read returns flags then clears them
// - wrap to 0x0000 / 0xFFFF, keep counting
// - entering up/down mode loads 0x7FFF
// - counts in sleep, interrupt wakes system
// - stop mode freezes counter and held state
// - after stop, held versus new state counts
// - noise filter drops pulses under 8 clocks
// - inputs synchronised, one clock of uncertainty
// - normal decoding counts after four transitions
// - quadruple decoding counts every single-step state change
// - direct 0<->3 changes ignored, progress cleared
// - sampling clock: low-speed tick or base/4
package qdc_pkg;

    // register byte offsets inside the slave window
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RUN = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0c;
    localparam logic [7:0] OFF_COUNT = 8'h10;

    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_SYNC_BIT = 3;
    localparam int CTRL_NF_BIT = 2;
    localparam int CTRL_QUAD_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // status register fields
    localparam int ST_OVF_BIT = 2;
    localparam int ST_UDF_BIT = 3;
    localparam int ST_CNT_BIT = 4;

    // run register fields
    localparam int RUN_RUN_BIT = 0;
    localparam int RUN_UDCE_BIT = 4;
    localparam int RUN_CK_BIT = 5;

    // mode register: clock select field, 00 means prescaler off
    localparam int MODE_CLK_LSB = 0;
    localparam logic [1:0] CLK_PRESCALER_OFF = 2'h0;

    // counter values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_INIT = 16'h7fff;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_MIN = 16'h0000;

    // timing counts: filter in system clocks, sample divider in base ticks
    localparam int FILTER_CLOCKS = 8;
    localparam logic [2:0] FILTER_LAST = 3'(FILTER_CLOCKS - 1);
    localparam int SAMPLE_DIV = 4;
    localparam logic [1:0] SAMPLE_DIV_LAST = 2'(SAMPLE_DIV - 1);

    // low-power state of the surrounding system
    typedef enum logic [1:0] {PM_NORMAL, PM_SLOW, PM_SLEEP, PM_STOP} qdc_power_t;

    // progress of a four-transition sequence in normal decoding
    typedef enum logic [2:0] {PR_IDLE, PR_UP1, PR_UP2, PR_UP3, PR_DN1, PR_DN2, PR_DN3} qdc_prog_t;

    // ahb-lite address phase
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
    } qdc_ahb_req_t;

    // control register contents
    typedef struct packed {
        logic enable;
        logic syncMode;
        logic noiseFilter;
        logic quadMode;
    } qdc_ctrl_t;

    // sticky status flags
    typedef struct packed {
        logic countEvent;
        logic underflow;
        logic overflow;
    } qdc_status_t;

endpackage

// ---- sim/qdc_encoder_model.sv ----
// qdc_encoder_model: behavioural two-phase pulse source for the counter channel.
// assumes the bench pulses one command at a time and waits for the counter to settle.
`timescale 1ns/1ps
module qdc_encoder_model (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // commands from the bench
    input wire logic stepUp,
    input wire logic stepDown,
    input wire logic jumpDiag,
    input wire logic glitchA,
    // encoder pins
    output logic phaseA,
    output logic phaseB
);
    logic [1:0] pinState_r;
    logic [2:0] glitchLeft_r;

    // gray walk: one pin moves per step, the other stays level around the change
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinState_r <= 2'h0;
        end else if (stepUp) begin
            pinState_r <= {~pinState_r[0], pinState_r[1]};
        end else if (stepDown) begin
            pinState_r <= {pinState_r[0], ~pinState_r[1]};
        end else if (jumpDiag) begin
            pinState_r <= ~pinState_r; // only on command: both pins at once
        end
    end

    // short pulse on phase a, four clocks wide, only when the bench asks for it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            glitchLeft_r <= 3'h0;
        end else if (glitchA) begin
            glitchLeft_r <= 3'h4;
        end else if (glitchLeft_r != 3'h0) begin
            glitchLeft_r <= glitchLeft_r - 3'h1;
        end
    end

    // pin outputs
    assign phaseA = pinState_r[1] ^ (glitchLeft_r != 3'h0);
    assign phaseB = pinState_r[0];
endmodule

// ---- sim/two_phase_updown_counter_test.sv ----
// two_phase_updown_counter_test: self-checking bench for the up/down counter channel.
// assumes qdc_counter answers with zero wait states and the encoder model drives its pins.
`timescale 1ns/1ps
module two_phase_updown_counter_test
    import qdc_pkg::*;
;
    logic clock, arst_n, hreadyout, hresp, countIrq, wakeReq;
    logic phaseA, phaseB, lowSpeedTick, prescaleBaseTick;
    logic stepUp, stepDown, jumpDiag, glitchA;
    logic [31:0] hwdata, hrdata, rdData;
    logic [15:0] countValue;
    qdc_ahb_req_t busReq;
    qdc_power_t powerMode;
    int miscompares, samples_checked, irqs, wakes, irqMark, cycles;

    qdc_counter u_qdc_counter (.clock(clock), .arst_n(arst_n), .busReq(busReq), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phaseA(phaseA),
        .phaseB(phaseB), .lowSpeedTick(lowSpeedTick), .prescaleBaseTick(prescaleBaseTick),
        .powerMode(powerMode), .countIrq(countIrq), .wakeReq(wakeReq), .countValue(countValue));

    qdc_encoder_model u_qdc_encoder_model (.clock(clock), .arst_n(arst_n), .stepUp(stepUp),
        .stepDown(stepDown), .jumpDiag(jumpDiag), .glitchA(glitchA), .phaseA(phaseA), .phaseB(phaseB));

    // 40 mhz system clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // pulse counters and hang guard; a pulse is seen at the edge after it rises
    always @(posedge clock) begin
        cycles++;
        if (countIrq === 1'b1) irqs++;
        if (wakeReq === 1'b1) wakes++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single ahb-lite transfer; entered just after a rising edge
    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        busReq <= '{1'b1, {24'h0, addr}, 2'h2, wr, 3'h2};
        @(posedge clock);
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
        while (hreadyout !== 1'b1) @(posedge clock);
        busReq <= '{1'b0, 32'h0, 2'h0, 1'b0, 3'h2};
        hwdata <= wr ? wd : 32'h0;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rdData = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task rd_check(input logic [7:0] addr, input logic [31:0] exp, input string what);
        bus(1'b0, addr, 32'h0);
        check(what, rdData, exp);
    endtask

    // kind 0 up, 1 down, 2 diagonal jump, 3 glitch; long enough for sync, filter and slow ticks
    task move(input logic [1:0] kind);
        stepUp <= (kind == 2'h0);
        stepDown <= (kind == 2'h1);
        jumpDiag <= (kind == 2'h2);
        glitchA <= (kind == 2'h3);
        @(posedge clock);
        {stepUp, stepDown, jumpDiag, glitchA} <= 4'h0;
        repeat (24) @(posedge clock);
    endtask

    task expect_cnt(input logic [15:0] exp, input int dIrq);
        rd_check(OFF_COUNT, {16'h0, exp}, "count register");
        check("countValue", {16'h0, countValue}, {16'h0, exp});
        check("irq pulses", 32'(irqs - irqMark), 32'(dIrq));
        irqMark = irqs;
    endtask

    task t_reset;
        rd_check(OFF_CTRL, 32'h0, "ctrl reset");
        rd_check(OFF_STATUS, 32'h0, "status reset");
        rd_check(OFF_RUN, 32'h0, "run reset");
        bus(1'b1, 8'h40, 32'hffffffff);
        rd_check(8'h40, 32'h0, "unmapped");
    endtask

    task t_setup;
        bus(1'b1, OFF_MODE, {30'h0, CLK_PRESCALER_OFF});
        bus(1'b1, OFF_CTRL, 32'hff);
        rd_check(OFF_CTRL, 32'h8e, "ctrl reserved bits");
        bus(1'b1, OFF_CTRL, 32'h82);
        bus(1'b1, OFF_RUN, 32'h11);
        expect_cnt(COUNT_INIT, 0);
    endtask

    task t_quad;
        repeat (4) move(2'h0);
        expect_cnt(16'h8003, 4);
        rd_check(OFF_STATUS, 32'h10, "status count");
        rd_check(OFF_STATUS, 32'h0, "status cleared");
        repeat (4) move(2'h1);
        expect_cnt(16'h7fff, 4);
    endtask

    task t_irregular;
        move(2'h2);
        move(2'h2);
        expect_cnt(16'h7fff, 0);
    endtask

    // unfiltered glitch counts up then down; filtered it must vanish
    task t_filter;
        move(2'h3);
        expect_cnt(16'h7fff, 2);
        bus(1'b1, OFF_CTRL, 32'h86);
        move(2'h3);
        expect_cnt(16'h7fff, 0);
        move(2'h0);
        expect_cnt(16'h8000, 1);
        move(2'h1);
        bus(1'b1, OFF_CTRL, 32'h82);
        expect_cnt(16'h7fff, 1);
    endtask

    task t_normal;
        bus(1'b1, OFF_CTRL, 32'h80);
        repeat (3) move(2'h0);
        expect_cnt(16'h7fff, 0);
        move(2'h0);
        expect_cnt(16'h8000, 1);
        repeat (4) move(2'h1);
        expect_cnt(16'h7fff, 1);
        bus(1'b1, OFF_CTRL, 32'h02);
        move(2'h0);
        expect_cnt(16'h7fff, 0);
        move(2'h1);
        bus(1'b1, OFF_CTRL, 32'h82);
    endtask

    // no low-speed tick: the base/4 path must take over once selected
    task t_sample;
        lowSpeedTick <= 1'b0;
        move(2'h0);
        expect_cnt(16'h7fff, 0);
        bus(1'b1, OFF_RUN, 32'h31);
        repeat (24) @(posedge clock);
        expect_cnt(16'h8000, 1);
        move(2'h1);
        bus(1'b1, OFF_RUN, 32'h11);
        lowSpeedTick <= 1'b1;
        expect_cnt(16'h7fff, 1);
    endtask

    task t_power;
        powerMode <= PM_STOP;
        move(2'h0);
        expect_cnt(16'h7fff, 0);
        powerMode <= PM_NORMAL;
        repeat (24) @(posedge clock);
        expect_cnt(16'h8000, 1);
        powerMode <= PM_SLEEP;
        move(2'h1);
        expect_cnt(16'h7fff, 1);
        check("wake pulses", 32'(wakes), 32'h1);
        powerMode <= PM_NORMAL;
    endtask

    // plain timer mode: phase a rising edge counts with no interrupt; re-entry reloads
    task t_timer;
        bus(1'b1, OFF_RUN, 32'h01);
        move(2'h0);
        expect_cnt(16'h8000, 0);
        bus(1'b1, OFF_RUN, 32'h11);
        expect_cnt(COUNT_INIT, 0);
    endtask

    // main sequence: reset held for ten clocks, then each scenario in turn
    initial begin
        busReq = '0;
        hwdata = 32'h0;
        arst_n = 1'b0;
        lowSpeedTick = 1'b1;
        prescaleBaseTick = 1'b1;
        {stepUp, stepDown, jumpDiag, glitchA} = 4'h0;
        powerMode = PM_NORMAL;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        check("countValue reset", {16'h0, countValue}, 32'h0);
        t_reset();
        t_setup();
        t_quad();
        t_irregular();
        t_filter();
        t_normal();
        t_sample();
        t_power();
        t_timer();
        test_done();
    end
endmodule
